// ### common/ddm_pkg.sv
package ddm_pkg;

  // ----------------------------------------------------------------
  // Register offsets on the three address lines
  // ----------------------------------------------------------------
  localparam logic [2:0] OFS_DATA = 3'h0;
  localparam logic [2:0] OFS_ERR_FEAT = 3'h1;
  localparam logic [2:0] OFS_HEAD = 3'h6;
  localparam logic [2:0] OFS_CMD_STAT = 3'h7;
  localparam logic [2:0] OFS_DEVICE_CONTROL = 3'h6;
  localparam logic [2:0] OFS_ALTERNATE_STATUS = 3'h6;
  localparam logic [2:0] OFS_DRIVE_ADDRESS = 3'h7;
  localparam int HEAD_DRIVE_BIT = 4;

  // ----------------------------------------------------------------
  // Command and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_SET_FEATURES = 8'hEF;
  localparam logic [7:0] FEAT_8BIT_ON = 8'h01;
  localparam logic [7:0] FEAT_8BIT_OFF = 8'h81;
  localparam logic [7:0] TF_RESET = 8'h00;
  localparam logic [7:0] DEVICE_CONTROL_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [3:0] IRQ_DISK_DEFAULT = 4'hE;

  // ----------------------------------------------------------------
  // Register mapping configurations
  // ----------------------------------------------------------------
  localparam logic [1:0] CFG_MEMORY = 2'h0;
  localparam logic [1:0] CFG_CONTIG_IO = 2'h1;
  localparam logic [1:0] CFG_PRIMARY_IO = 2'h2;
  localparam logic [1:0] CFG_SECONDARY_IO = 2'h3;
  localparam logic [10:0] PRI_TF_BASE = 11'h1F0;
  localparam logic [10:0] PRI_CTL_BASE = 11'h3F6;
  localparam logic [10:0] SEC_TF_BASE = 11'h170;
  localparam logic [10:0] SEC_CTL_BASE = 11'h376;
  localparam logic [3:0] OFS_MAP_DUP_EVEN = 4'h8;
  localparam logic [3:0] OFS_MAP_ALT = 4'hE;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic primary_select_n;
    logic secondary_select_n;
    logic dma_ack_n;
    logic io_read_strobe_n;
    logic io_write_strobe_n;
    logic [2:0] addr;
    logic [15:0] data;
  } ddm_host_t;

  typedef struct packed {
    logic [15:0] data;
    logic oe_lo;
    logic oe_hi;
  } ddm_drive_t;

  typedef struct packed {
    logic tf_rd;
    logic tf_wr;
    logic pio_rd;
    logic pio_wr;
    logic dma_rd;
    logic dma_wr;
    logic ctl_wr;
    logic alt_rd;
    logic drv_rd;
    logic invalid;
  } ddm_access_t;

  typedef enum logic [2:0] {
    MODE_POWER_ON = 3'b001,
    MODE_DIRECT_DISK = 3'b010,
    MODE_CARD_SLOT_ATA = 3'b100
  } ddm_mode_t;

endpackage

// ### logic/ddm_cfg_map.sv
`timescale 1ns/1ns
module ddm_cfg_map
  import ddm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] cfg_index,
  input wire logic [10:0] slot_addr,
  input wire logic slot_is_io,
  output logic map_hit,
  output logic [3:0] map_offset
);

  logic next_hit;
  logic [3:0] next_offset;

  function automatic logic in_block(input logic [10:0] a, input logic [10:0] base, input int span_bits);
    logic [10:0] mask;
    mask = ~((11'h001 << span_bits) - 11'h001);
    return (a & mask) == (base & mask);
  endfunction

  always_comb
  begin
    next_hit = 1'b0;
    next_offset = 4'h0;
    case (cfg_index)
      CFG_MEMORY:
      begin
        // Upper 1 kB window folds onto the duplicate data pair
        next_hit = !slot_is_io;
        next_offset = slot_addr[10] ? {OFS_MAP_DUP_EVEN[3:1], slot_addr[0]} : slot_addr[3:0];
      end
      CFG_CONTIG_IO:
      begin
        // Host decodes the 16-byte block; only the low nibble matters here
        next_hit = slot_is_io;
        next_offset = slot_addr[3:0];
      end
      CFG_PRIMARY_IO, CFG_SECONDARY_IO:
      begin
        if (slot_is_io && in_block(slot_addr, (cfg_index == CFG_PRIMARY_IO) ? PRI_TF_BASE : SEC_TF_BASE, 3))
        begin
          next_hit = 1'b1;
          next_offset = {1'b0, slot_addr[2:0]};
        end
        else if (slot_is_io && in_block(slot_addr, (cfg_index == CFG_PRIMARY_IO) ? PRI_CTL_BASE : SEC_CTL_BASE, 1))
        begin
          next_hit = 1'b1;
          next_offset = {OFS_MAP_ALT[3:1], slot_addr[0]};
        end
      end
      default:
      begin
        next_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      map_hit <= 1'b0;
      map_offset <= 4'h0;
    end
    else
    begin
      map_hit <= next_hit;
      map_offset <= next_offset;
    end
  end

endmodule

// ### logic/ddm_port.sv
`timescale 1ns/1ns
module ddm_port
  import ddm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic output_enable_strap_n,
  input wire logic card_present,
  input ddm_pkg::ddm_host_t host,
  output ddm_pkg::ddm_drive_t drive,
  input wire logic [7:0] core_status,
  input wire logic [7:0] core_error,
  input wire logic [15:0] core_rd_word,
  output logic core_rd_take,
  output logic [15:0] core_wr_word,
  output logic core_wr_valid,
  output logic [7:0] core_cmd,
  output logic core_cmd_valid,
  output logic [7:0] device_control,
  output logic eight_bit_mode,
  output logic invalid_access,
  output ddm_pkg::ddm_mode_t mode,
  input wire logic [1:0] cfg_index,
  input wire logic [3:0] irq_select,
  input wire logic irq_use_default,
  input wire logic [10:0] slot_addr,
  input wire logic slot_is_io,
  output logic map_hit,
  output logic [3:0] map_offset,
  output logic [3:0] irq_line
);

  // ----------------------------------------------------------------
  // Pin decode
  // ----------------------------------------------------------------
  function automatic ddm_access_t decode(input ddm_host_t h);
    ddm_access_t a;
    logic cs0;
    logic cs1;
    logic ack;
    logic rd;
    logic wr;
    a = '0;
    cs0 = !h.primary_select_n;
    cs1 = !h.secondary_select_n;
    ack = !h.dma_ack_n;
    rd = !h.io_read_strobe_n;
    wr = !h.io_write_strobe_n;
    // A DMA write with the primary select low is legal, so it is excluded here
    a.invalid = (cs0 && cs1) || (ack && cs1 && (rd || wr)) || (ack && cs0 && rd);
    if (!a.invalid)
    begin
      a.tf_rd = cs0 && !ack && rd && (h.addr != OFS_DATA);
      a.tf_wr = cs0 && !ack && wr && (h.addr != OFS_DATA);
      a.pio_rd = cs0 && !ack && rd && (h.addr == OFS_DATA);
      a.pio_wr = cs0 && !ack && wr && (h.addr == OFS_DATA);
      a.dma_wr = cs0 && ack && wr;
      a.dma_rd = !cs0 && !cs1 && ack && rd;
      a.ctl_wr = cs1 && !ack && wr && (h.addr == OFS_DEVICE_CONTROL);
      a.alt_rd = cs1 && !ack && rd && (h.addr == OFS_ALTERNATE_STATUS);
      a.drv_rd = cs1 && !ack && rd && (h.addr == OFS_DRIVE_ADDRESS);
    end
    return a;
  endfunction

  function automatic logic [7:0] drive_address_of(input logic [7:0] head);
    return {2'b11, ~head[3:0], head[HEAD_DRIVE_BIT], ~head[HEAD_DRIVE_BIT]};
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ddm_mode_t next_mode;
  logic [7:0] tf [1:6];
  logic [7:0] next_tf [1:6];
  logic prev_wr_n;
  logic prev_rd_n;
  logic prev_present;
  logic byte_phase;
  logic next_byte_phase;
  logic [7:0] byte_hold;
  logic [7:0] next_byte_hold;
  ddm_drive_t next_drive;
  logic next_rd_take;
  logic [15:0] next_wr_word;
  logic next_wr_valid;
  logic [7:0] next_cmd;
  logic next_cmd_valid;
  logic [7:0] next_device_control;
  logic next_eight_bit;
  logic next_invalid;
  logic [3:0] next_irq_line;
  ddm_access_t acc;
  logic wr_edge;
  logic rd_edge;
  logic active;

  always_comb
  begin
    acc = decode(host);
    wr_edge = prev_wr_n && !host.io_write_strobe_n;
    rd_edge = prev_rd_n && !host.io_read_strobe_n;
    active = (mode == MODE_DIRECT_DISK);
    next_mode = mode;
    next_tf = tf;
    next_byte_phase = byte_phase;
    next_byte_hold = byte_hold;
    next_drive = '0;
    next_rd_take = 1'b0;
    next_wr_word = core_wr_word;
    next_wr_valid = 1'b0;
    next_cmd = core_cmd;
    next_cmd_valid = 1'b0;
    next_device_control = device_control;
    next_eight_bit = eight_bit_mode;
    next_invalid = active && acc.invalid && (!host.io_read_strobe_n || !host.io_write_strobe_n);
    next_irq_line = irq_select;

    // Mode selection
    case (mode)
      MODE_POWER_ON:
      begin
        // Strap is sampled on the first edge after reset releases
        next_mode = output_enable_strap_n ? MODE_CARD_SLOT_ATA : MODE_DIRECT_DISK;
      end
      MODE_DIRECT_DISK:
      begin
        if (card_present && !prev_present)
        begin
          next_mode = MODE_CARD_SLOT_ATA;
        end
      end
      MODE_CARD_SLOT_ATA:
      begin
        next_mode = MODE_CARD_SLOT_ATA;
      end
      default:
      begin
        next_mode = MODE_POWER_ON;
      end
    endcase

    // Interrupt line for the selected mapping
    if ((cfg_index == CFG_PRIMARY_IO || cfg_index == CFG_SECONDARY_IO) && irq_use_default)
    begin
      next_irq_line = IRQ_DISK_DEFAULT;
    end

    if (active)
    begin
      // Writes act once, on the falling edge of the write strobe
      if (wr_edge && acc.tf_wr)
      begin
        if (host.addr == OFS_CMD_STAT)
        begin
          next_cmd = host.data[7:0];
          next_cmd_valid = 1'b1;
          if (host.data[7:0] == CMD_SET_FEATURES && tf[OFS_ERR_FEAT] == FEAT_8BIT_ON)
          begin
            next_eight_bit = 1'b1;
            next_byte_phase = 1'b0;
          end
          else if (host.data[7:0] == CMD_SET_FEATURES && tf[OFS_ERR_FEAT] == FEAT_8BIT_OFF)
          begin
            next_eight_bit = 1'b0;
            next_byte_phase = 1'b0;
          end
        end
        else
        begin
          next_tf[host.addr] = host.data[7:0];
        end
      end
      if (wr_edge && (acc.pio_wr || acc.dma_wr))
      begin
        if (eight_bit_mode)
        begin
          // Byte pairs build a word, even byte first
          if (!byte_phase)
          begin
            next_byte_hold = host.data[7:0];
            next_byte_phase = 1'b1;
          end
          else
          begin
            next_wr_word = {host.data[7:0], byte_hold};
            next_wr_valid = 1'b1;
            next_byte_phase = 1'b0;
          end
        end
        else
        begin
          next_wr_word = host.data;
          next_wr_valid = 1'b1;
        end
      end
      if (wr_edge && acc.ctl_wr)
      begin
        next_device_control = host.data[7:0];
      end

      // Reads drive while the strobe is low; a word is consumed on its last piece
      if (acc.tf_rd)
      begin
        next_drive.oe_lo = 1'b1;
        case (host.addr)
          OFS_ERR_FEAT: next_drive.data[7:0] = core_error;
          OFS_CMD_STAT: next_drive.data[7:0] = core_status;
          default: next_drive.data[7:0] = tf[host.addr];
        endcase
      end
      if (acc.alt_rd)
      begin
        next_drive.oe_lo = 1'b1;
        next_drive.data[7:0] = core_status;
      end
      if (acc.drv_rd)
      begin
        next_drive.oe_lo = 1'b1;
        next_drive.data[7:0] = drive_address_of(tf[OFS_HEAD]);
      end
      if (acc.pio_rd || acc.dma_rd)
      begin
        if (eight_bit_mode)
        begin
          next_drive.oe_lo = 1'b1;
          // Phase flips at the strobe edge; the rest of the strobe keeps showing the byte picked there
          next_drive.data[7:0] = (byte_phase == rd_edge) ? core_rd_word[15:8] : core_rd_word[7:0];
          if (rd_edge)
          begin
            next_byte_phase = !byte_phase;
            next_rd_take = byte_phase;
          end
        end
        else
        begin
          next_drive.oe_lo = 1'b1;
          next_drive.oe_hi = 1'b1;
          next_drive.data = core_rd_word;
          next_rd_take = rd_edge;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode <= MODE_POWER_ON;
      for (int i = 1; i <= 6; i++)
      begin
        tf[i] <= TF_RESET;
      end
      prev_wr_n <= 1'b1;
      prev_rd_n <= 1'b1;
      prev_present <= 1'b1;
      byte_phase <= 1'b0;
      byte_hold <= TF_RESET;
      drive <= '0;
      core_rd_take <= 1'b0;
      core_wr_word <= WORD_RESET;
      core_wr_valid <= 1'b0;
      core_cmd <= TF_RESET;
      core_cmd_valid <= 1'b0;
      device_control <= DEVICE_CONTROL_RESET;
      eight_bit_mode <= 1'b0;
      invalid_access <= 1'b0;
      irq_line <= IRQ_DISK_DEFAULT;
    end
    else
    begin
      mode <= next_mode;
      tf <= next_tf;
      prev_wr_n <= host.io_write_strobe_n;
      prev_rd_n <= host.io_read_strobe_n;
      prev_present <= card_present;
      byte_phase <= next_byte_phase;
      byte_hold <= next_byte_hold;
      drive <= next_drive;
      core_rd_take <= next_rd_take;
      core_wr_word <= next_wr_word;
      core_wr_valid <= next_wr_valid;
      core_cmd <= next_cmd;
      core_cmd_valid <= next_cmd_valid;
      device_control <= next_device_control;
      eight_bit_mode <= next_eight_bit;
      invalid_access <= next_invalid;
      irq_line <= next_irq_line;
    end
  end

  // ----------------------------------------------------------------
  // Register mapping decode
  // ----------------------------------------------------------------
  ddm_cfg_map u_map (
    .clk(clk),
    .rst_n(rst_n),
    .cfg_index(cfg_index),
    .slot_addr(slot_addr),
    .slot_is_io(slot_is_io),
    .map_hit(map_hit),
    .map_offset(map_offset)
  );

endmodule

// ### test/ddm_port_checker.sv
`timescale 1ns/1ns
module ddm_port_checker
  import ddm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic output_enable_strap_n,
  input ddm_pkg::ddm_host_t host,
  input ddm_pkg::ddm_drive_t drive,
  input wire logic [7:0] core_status,
  input wire logic [15:0] core_rd_word,
  input wire logic [15:0] core_wr_word,
  input wire logic core_wr_valid,
  input wire logic [7:0] core_cmd,
  input wire logic core_cmd_valid,
  input wire logic [7:0] device_control,
  input wire logic eight_bit_mode,
  input wire logic invalid_access,
  input ddm_pkg::ddm_mode_t mode,
  input wire logic [1:0] cfg_index,
  input wire logic irq_use_default,
  input wire logic [3:0] irq_line
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic wr_prev;
  logic wr_fall, rd_on, dd, pri, sec, dma_w, dma_r;
  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      wr_prev <= 1'b1;
    else
      wr_prev <= host.io_write_strobe_n;
  assign wr_fall = !host.io_write_strobe_n && wr_prev;
  assign rd_on = !host.io_read_strobe_n;
  assign dd = mode == MODE_DIRECT_DISK;
  assign pri = dd && !host.primary_select_n && host.secondary_select_n && host.dma_ack_n;
  assign sec = dd && host.primary_select_n && !host.secondary_select_n && host.dma_ack_n;
  assign dma_w = dd && !host.primary_select_n && host.secondary_select_n && !host.dma_ack_n;
  assign dma_r = dd && host.primary_select_n && host.secondary_select_n && !host.dma_ack_n;
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_data_word_write: assert property (pri && !eight_bit_mode && host.addr == OFS_DATA && wr_fall
    |=> core_wr_valid && core_wr_word == $past(host.data)) else $error("data word write lost");
  a_dma_word_write: assert property (dma_w && !eight_bit_mode && wr_fall
    |=> core_wr_valid && core_wr_word == $past(host.data)) else $error("dma word write lost");
  a_command_write: assert property (pri && host.addr == OFS_CMD_STAT && wr_fall
    |=> core_cmd_valid && core_cmd == $past(host.data[7:0])) else $error("command write lost");
  a_control_write: assert property (sec && host.addr == OFS_DEVICE_CONTROL && wr_fall
    |=> device_control == $past(host.data[7:0])) else $error("control write lost");
  a_word_read: assert property ((pri && host.addr == OFS_DATA || dma_r) && rd_on && !eight_bit_mode
    |=> drive.oe_lo && drive.oe_hi && drive.data == $past(core_rd_word)) else $error("word read wrong");
  a_alt_status_read: assert property (sec && host.addr == OFS_ALTERNATE_STATUS && rd_on
    |=> drive.oe_lo && !drive.oe_hi && drive.data[7:0] == $past(core_status)) else $error("alt status wrong");
  a_byte_read_low: assert property (pri && host.addr != OFS_DATA && rd_on
    |=> drive.oe_lo && !drive.oe_hi) else $error("task file read lanes wrong");
  a_invalid_quiet: assert property (dd && !host.primary_select_n && !host.secondary_select_n
    && !(host.io_read_strobe_n && host.io_write_strobe_n) |=> invalid_access && !core_wr_valid && !drive.oe_lo)
    else $error("invalid access not refused");
  a_mode_decide: assert property (mode == MODE_POWER_ON
    |=> mode == ($past(output_enable_strap_n) ? MODE_CARD_SLOT_ATA : MODE_DIRECT_DISK)) else $error("mode wrong");
  a_irq_default: assert property (cfg_index[1] && irq_use_default |=> irq_line == IRQ_DISK_DEFAULT)
    else $error("default irq wrong");
  a_slot_no_decode: assert property (mode == MODE_CARD_SLOT_ATA
    |=> !drive.oe_lo && !core_wr_valid && !invalid_access) else $error("decode outside direct mode");
  c_word_write: cover property (core_wr_valid);
  c_eight_bit: cover property (eight_bit_mode);
  c_invalid: cover property (invalid_access);
  c_card_slot: cover property (mode == MODE_CARD_SLOT_ATA);
endmodule

bind ddm_port ddm_port_checker ddm_port_checker_i (.clk(clk), .rst_n(rst_n),
  .output_enable_strap_n(output_enable_strap_n), .host(host), .drive(drive), .core_status(core_status),
  .core_rd_word(core_rd_word), .core_wr_word(core_wr_word), .core_wr_valid(core_wr_valid), .core_cmd(core_cmd),
  .core_cmd_valid(core_cmd_valid), .device_control(device_control), .eight_bit_mode(eight_bit_mode),
  .invalid_access(invalid_access), .mode(mode), .cfg_index(cfg_index), .irq_use_default(irq_use_default),
  .irq_line(irq_line));

// ### test/ddm_host_model.sv
`timescale 1ns/1ns
module ddm_host_model
  import ddm_pkg::*;
(
  input wire logic clk,
  input ddm_pkg::ddm_drive_t drive,
  output ddm_pkg::ddm_host_t host
);
  initial host = {5'h1F, 3'h0, 16'h5A5A};
  // Only original-speed strobes with a single card on the bus
  task automatic xfer(input logic [2:0] sel, input logic [2:0] a, input logic [15:0] d, input logic wr,
                      output ddm_pkg::ddm_drive_t seen);
    {host.secondary_select_n, host.primary_select_n, host.dma_ack_n} = sel;
    host.addr = a;
    // Released data lines flip so a stale value never looks driven
    host.data = wr ? d : ~host.data;
    if (wr)
      host.io_write_strobe_n = 1'b0;
    else
      host.io_read_strobe_n = 1'b0;
    @(negedge clk);
    host.io_write_strobe_n = 1'b1;
    @(negedge clk);
    seen = drive;
    host.io_read_strobe_n = 1'b1;
    {host.secondary_select_n, host.primary_select_n, host.dma_ack_n} = 3'h7;
    host.data = ~host.data;
    // Idle for one more edge so the next call never re-drives the selects in this time step
    @(negedge clk);
  endtask
endmodule

// ### test/ddm_port_tb_top.sv
`timescale 1ns/1ns
module ddm_port_tb_top;
  import ddm_pkg::*;
  localparam logic [2:0] PIO = 3'h5, SEC = 3'h3, DMAW = 3'h4, DMAR = 3'h6;
  logic clk = 1'b0, rst_n = 1'b0, output_enable_strap_n = 1'b0, card_present = 1'b1;
  logic [7:0] core_status = 8'h50, core_error = 8'h04, core_cmd, device_control;
  logic [15:0] core_rd_word = 16'h1234, core_wr_word;
  logic [1:0] cfg_index = CFG_PRIMARY_IO;
  logic [3:0] irq_select = 4'h5, map_offset, irq_line;
  logic irq_use_default = 1'b1, slot_is_io = 1'b1;
  logic [10:0] slot_addr = 11'h1F3;
  logic core_rd_take, core_wr_valid, core_cmd_valid, eight_bit_mode, invalid_access, map_hit;
  logic [3:0] pulses;
  ddm_host_t host;
  ddm_drive_t drive, got;
  ddm_mode_t mode;
  logic [10:0] maps [4] = '{11'h401, 11'h2A5, 11'h1F3, 11'h376};
  logic [3:0] moff [4] = '{4'h9, 4'h5, 4'h3, 4'hE};
  logic [31:0] seed = 32'h0000B226;
  logic [31:0] r;
  int checks = 0, miscompares = 0, cycles = 0;

  ddm_port ddm_port_i (.clk(clk), .rst_n(rst_n), .output_enable_strap_n(output_enable_strap_n),
    .card_present(card_present), .host(host), .drive(drive), .core_status(core_status), .core_error(core_error),
    .core_rd_word(core_rd_word), .core_rd_take(core_rd_take), .core_wr_word(core_wr_word),
    .core_wr_valid(core_wr_valid), .core_cmd(core_cmd), .core_cmd_valid(core_cmd_valid),
    .device_control(device_control), .eight_bit_mode(eight_bit_mode), .invalid_access(invalid_access),
    .mode(mode), .cfg_index(cfg_index), .irq_select(irq_select), .irq_use_default(irq_use_default),
    .slot_addr(slot_addr), .slot_is_io(slot_is_io), .map_hit(map_hit), .map_offset(map_offset),
    .irq_line(irq_line));
  ddm_host_model ddm_host_model_i (.clk(clk), .drive(drive), .host(host));

  always #2 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] drv_addr(input logic [7:0] h);
    return {2'h3, ~h[3:0], h[HEAD_DRIVE_BIT], ~h[HEAD_DRIVE_BIT]};
  endfunction
  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic xf(input logic [2:0] s, input logic [2:0] a, input logic [15:0] d, input logic w);
    fork
      ddm_host_model_i.xfer(s, a, d, w, got);
      begin
        // Pulses other than invalid_access on a read stand only in the cycle after the strobe edge
        @(negedge clk);
        pulses = {invalid_access, core_wr_valid, core_cmd_valid, core_rd_take};
      end
    join
  endtask
  task automatic wr(input logic [2:0] s, input logic [2:0] a, input logic [15:0] d);
    xf(s, a, d, 1'b1);
  endtask
  task automatic rd(input logic [2:0] s, input logic [2:0] a);
    xf(s, a, 16'h0000, 1'b0);
  endtask
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    do_reset();
    check("mode", mode, MODE_DIRECT_DISK);
    check("ctl_rst", device_control, DEVICE_CONTROL_RESET);
    repeat (8)
    begin
      r = xs();
      wr(PIO, OFS_DATA, r[15:0]);
      check("pio_wr", {pulses[2], core_wr_word}, {1'b1, r[15:0]});
      wr(DMAW, r[18:16], r[31:16]);
      check("dma_wr", {pulses[2], core_wr_word}, {1'b1, r[31:16]});
      core_rd_word = r[31:16];
      rd(PIO, OFS_DATA);
      check("pio_rd", {pulses[0], got.oe_lo, got.oe_hi, got.data}, {3'h7, r[31:16]});
      rd(DMAR, r[2:0]);
      check("dma_rd", {pulses[0], got.oe_lo, got.oe_hi, got.data}, {3'h7, r[31:16]});
    end
    for (int a = 2; a < 6; a++)
    begin
      r = xs();
      wr(PIO, 3'(a), r[15:0]);
      rd(PIO, 3'(a));
      check("tf", {got.oe_lo, got.oe_hi, got.data[7:0]}, {2'h2, r[7:0]});
    end
    wr(PIO, OFS_HEAD, r[31:16]);
    rd(SEC, OFS_DRIVE_ADDRESS);
    check("drv_addr", {got.oe_lo, got.oe_hi, got.data[7:0]}, {2'h2, drv_addr(r[23:16])});
    rd(PIO, OFS_ERR_FEAT);
    check("error", got.data[7:0], core_error);
    rd(PIO, OFS_CMD_STAT);
    check("status", got.data[7:0], core_status);
    rd(SEC, OFS_ALTERNATE_STATUS);
    check("alt", {got.oe_lo, got.oe_hi, got.data[7:0]}, {2'h2, core_status});
    wr(SEC, OFS_DEVICE_CONTROL, r[15:0]);
    check("ctl", device_control, r[7:0]);
    wr(PIO, OFS_CMD_STAT, 16'h00C4);
    check("cmd", {pulses[1], core_cmd}, 9'h1C4);
    wr(3'h1, OFS_DATA, 16'hBEEF);
    check("inv_wr", {pulses[3], pulses[2]}, 2'h2);
    rd(3'h2, OFS_DATA);
    check("inv_rd", {pulses[3], got.oe_lo, got.oe_hi}, 3'h4);
    wr(PIO, OFS_ERR_FEAT, {8'h00, FEAT_8BIT_ON});
    wr(PIO, OFS_CMD_STAT, {8'h00, CMD_SET_FEATURES});
    check("8bit_on", eight_bit_mode, 1'b1);
    r = xs();
    wr(PIO, OFS_DATA, {8'h00, r[7:0]});
    check("half", pulses[2], 1'b0);
    wr(PIO, OFS_DATA, {8'h00, r[15:8]});
    check("pair", {pulses[2], core_wr_word}, {1'b1, r[15:0]});
    rd(PIO, OFS_DATA);
    check("rd_even", {pulses[0], got.oe_lo, got.oe_hi, got.data[7:0]}, {3'h2, core_rd_word[7:0]});
    rd(PIO, OFS_DATA);
    check("rd_odd", {pulses[0], got.oe_lo, got.oe_hi, got.data[7:0]}, {3'h6, core_rd_word[15:8]});
    wr(PIO, OFS_ERR_FEAT, {8'h00, FEAT_8BIT_OFF});
    wr(PIO, OFS_CMD_STAT, {8'h00, CMD_SET_FEATURES});
    check("8bit_off", eight_bit_mode, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      cfg_index = 2'(i);
      slot_addr = maps[i];
      slot_is_io = i != 0;
      repeat (2) @(negedge clk);
      check("map", {map_hit, map_offset}, {1'b1, moff[i]});
      check("irq", irq_line, i >= 2 ? IRQ_DISK_DEFAULT : irq_select);
    end
    irq_use_default = 1'b0;
    irq_select = r[19:16];
    repeat (2) @(negedge clk);
    check("irq_sel", irq_line, r[19:16]);
    card_present = 1'b0;
    repeat (2) @(negedge clk);
    card_present = 1'b1;
    repeat (2) @(negedge clk);
    check("reinsert", mode, MODE_CARD_SLOT_ATA);
    wr(PIO, OFS_DATA, 16'h1111);
    check("slot_quiet", {pulses[3], pulses[2]}, 2'h0);
    output_enable_strap_n = 1'b1;
    do_reset();
    check("strap_high", mode, MODE_CARD_SLOT_ATA);
    tally_and_finish();
  end
endmodule
